// File: rtl/cac_consts.vh
// Constants for the card adapter channel transfer block
`ifndef CAC_CONSTS_VH
`define CAC_CONSTS_VH

`define CAC_CLK_PERIOD_NS      4
`define CAC_REQ_PULSE_NS       600
`define CAC_REQ_PULSE_CYC      ((`CAC_REQ_PULSE_NS + `CAC_CLK_PERIOD_NS - 1) / `CAC_CLK_PERIOD_NS)
`define CAC_TAG_DELAY_NS       150
`define CAC_TAG_DELAY_CYC      ((`CAC_TAG_DELAY_NS + `CAC_CLK_PERIOD_NS - 1) / `CAC_CLK_PERIOD_NS)
`define CAC_T4_CYC             4
`define CAC_COLS               80
`define CAC_COL_W              7
`define CAC_PRESET_WRITE       7'h63
`define CAC_PRESET_READ        7'h4E
`define CAC_WRITE_LIMIT        7'h13
`define CAC_SEL_CHAR           3'h0
`define CAC_CNT_W              8

`endif

// File: rtl/cac_skid_buf.v
// Two-entry buffer with valid and ready on both sides
`default_nettype none
module cac_skid_buf (
  input  wire        clk,
  input  wire        srst,
  input  wire        in_valid,
  output wire        in_ready,
  input  wire [11:0] in_data,
  output wire        out_valid,
  input  wire        out_ready,
  output wire [11:0] out_data
);
  reg  [11:0] mem_reg [0:1];
  reg         wr_ptr_reg;
  reg         rd_ptr_reg;
  reg  [1:0]  count_reg;

  assign in_ready  = (count_reg != 2'h2);
  assign out_valid = (count_reg != 2'h0);
  assign out_data  = mem_reg[rd_ptr_reg];

  always @(posedge clk) begin
    if (srst) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg  <= 2'h0;
      mem_reg[0] <= 12'h000;
      mem_reg[1] <= 12'h000;
    end else begin
      if (in_valid && in_ready) begin
        mem_reg[wr_ptr_reg] <= in_data;
        wr_ptr_reg          <= ~wr_ptr_reg;
      end
      if (out_valid && out_ready)
        rd_ptr_reg <= ~rd_ptr_reg;
      case ({in_valid && in_ready, out_valid && out_ready})
        2'b10:   count_reg <= count_reg + 2'h1;
        2'b01:   count_reg <= count_reg - 2'h1;
        default: count_reg <= count_reg;
      endcase
    end
  end
endmodule // cac_skid_buf
`default_nettype wire

// File: rtl/cac_channel_xfer.v
// Channel-side transfer logic of the card adapter
`default_nettype none
`include "cac_consts.vh"
//
// Summary of operation
// - On poll, present address and status; if accepted, deselect and await command.
// - If stacked, deselect yet hold request in and keep blocking select in.
// - Character mode moves one byte per column; fewer than 80 columns allowed.
// - Read in character mode sets output select code 000 for converter data.
// - Service out inactive enables tag timing and sets command-in-progress until done.
// - Service out low with read-data-ready fires 600 ns pulse, then sets transfer request.
// - 150 ns after transfer request, tag enable raises service in.
// - Service out high on input gives one next-char request; data request stays clear and ready stays set.
// - Input prep shifts buffer, drops service in, decrements counter, sets data ready.
// - Input characters repeat until terminated or column counter reaches zero.
// - Punch in character mode converts bus out into buffer input.
// - First drop on output fires start-write and preset: write flag, counter 99, feed flag.
// - Punch-request pulse sets transfer request; service in rises 150 ns later.
// - Service out high on output, with the buffer entry path ready, raises overlap strobe; T4 clears transfer request.
// - Strobe end decrements counter and queues the new character for buffer load, without a buffer shift.
// - Each accepted non-zero output character increments the non-zero counter.
// - Write-in-progress flag clears after the 80th output byte.
// - Later drops only retrigger punch request; stop when terminated or 80 accepted.
// - First card is offset in the stacker when a feed command completes.
// - First phase-two pulse after card load sets the read-data-ready flag.
// - After load shifting, column counter presets to 78 and holds at zero after the 78th count.
//
module cac_channel_xfer (
  input  wire        clk,
  input  wire        srst,
  input  wire        poll_active,
  input  wire        status_accepted,
  input  wire        status_stacked,
  input  wire        status_suppressed,
  input  wire        status_pending_set,
  input  wire [7:0]  device_address,
  input  wire [7:0]  device_status,
  input  wire        select_read,
  input  wire        select_punch,
  input  wire        card_image,
  input  wire        feed_command,
  input  wire        terminate,
  input  wire        load_phase_two,
  input  wire        load_done,
  input  wire        service_out,
  input  wire [7:0]  bus_out,
  input  wire [11:0] buffer_head,
  input  wire        buffer_ready,
  output wire        request_in,
  output wire        select_in_block,
  output reg  [7:0]  bus_in,
  output wire        service_in,
  output reg  [2:0]  output_select,
  output wire        cmd_in_progress_flag,
  output wire        xfer_request_flag,
  output wire        write_in_progress_flag,
  output wire        feed_inhibit_flag,
  output wire        service_overlap_strobe,
  output wire        next_char_request,
  output wire        service_exchange_active,
  output reg         buffer_shift,
  output wire        buffer_load_valid,
  output wire [11:0] buffer_load_data,
  output reg  [`CAC_COL_W-1:0] column_count,
  output reg  [`CAC_CNT_W-1:0] nonzero_count,
  output reg         stacker_offset,
  output wire        xfer_done
);
  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function [11:0] char_to_card;
    input [7:0] ch;
    begin
      char_to_card = {ch[7:4], 4'h0, ch[3:0]};
    end
  endfunction

  function [7:0] card_to_char;
    input [11:0] cc;
    begin
      card_to_char = {cc[11:8], cc[3:0]};
    end
  endfunction

  localparam [3:0] ST_IDLE  = 4'h1;
  localparam [3:0] ST_PULSE = 4'h2;
  localparam [3:0] ST_TAG   = 4'h4;
  localparam [3:0] ST_WAIT  = 4'h8;
  localparam integer REQ_CYC_I = `CAC_REQ_PULSE_CYC;
  localparam integer TAG_CYC_I = `CAC_TAG_DELAY_CYC;
  localparam integer T4_CYC_I  = `CAC_T4_CYC;
  localparam [7:0]   REQ_CYC   = REQ_CYC_I[7:0];
  localparam [7:0]   TAG_CYC   = TAG_CYC_I[7:0];
  localparam [7:0]   T4_CYC    = T4_CYC_I[7:0];

  reg  [3:0] state_reg;
  reg  [7:0] timer_reg;
  reg        req_pend_reg;
  reg        stacked_reg;
  reg        poll_seen_reg;
  reg        cmd_reg;
  reg        xfer_reg;
  reg        tag_reg;
  reg        write_reg;
  reg        feed_reg;
  reg        rdr_reg;
  reg        data_req_reg;
  reg        ndr_reg;
  reg        service_overlap_strobe_reg;
  reg        svo_prev_reg;
  reg        first_reg;
  reg  [6:0] accepted_reg;
  reg        buf_valid_reg;
  reg [11:0] buf_data_reg;
  wire       buf_in_ready;
  wire       svo_fall;
  wire       svo_rise;
  wire       col_zero;

  assign svo_fall                = svo_prev_reg && !service_out;
  assign svo_rise                = !svo_prev_reg && service_out;
  assign col_zero                = (column_count == 7'h00);
  assign request_in              = req_pend_reg;
  assign select_in_block         = req_pend_reg;
  assign service_in              = tag_reg;
  assign cmd_in_progress_flag    = cmd_reg;
  assign xfer_request_flag       = xfer_reg;
  assign write_in_progress_flag  = write_reg;
  assign feed_inhibit_flag       = feed_reg;
  assign service_overlap_strobe  = service_overlap_strobe_reg;
  assign next_char_request       = ndr_reg;
  assign service_exchange_active = xfer_reg && service_out;
  assign xfer_done               = cmd_reg && (terminate || (select_read && col_zero &&
                                   !xfer_reg) || (select_punch && !write_reg && !first_reg));

  // ----------------------------------------
  // Buffer entry path
  // ----------------------------------------
  cac_skid_buf u_buf (
    .clk       (clk),
    .srst      (srst),
    .in_valid  (buf_valid_reg),
    .in_ready  (buf_in_ready),
    .in_data   (buf_data_reg),
    .out_valid (buffer_load_valid),
    .out_ready (buffer_ready),
    .out_data  (buffer_load_data)
  );

  // ----------------------------------------
  // Poll and status
  // ----------------------------------------
  always @(posedge clk) begin
    if (srst) begin
      req_pend_reg  <= 1'b0;
      stacked_reg   <= 1'b0;
      poll_seen_reg <= 1'b0;
      bus_in        <= 8'h00;
    end else begin
      poll_seen_reg <= poll_active;
      if (poll_active && !poll_seen_reg)
        bus_in <= device_address;
      else if (poll_active)
        bus_in <= device_status;
      else if (cmd_reg && select_read && !card_image)
        bus_in <= card_to_char(buffer_head);
      if (status_pending_set || (poll_active && status_stacked)) begin
        req_pend_reg <= 1'b1;
        stacked_reg  <= status_stacked;
      end else if (poll_active && (status_accepted || status_suppressed)) begin
        req_pend_reg <= 1'b0;
        stacked_reg  <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Transfer sequencer
  // ----------------------------------------
  always @(posedge clk) begin
    if (srst) begin
      state_reg      <= ST_IDLE;
      timer_reg      <= 8'h00;
      cmd_reg        <= 1'b0;
      xfer_reg       <= 1'b0;
      tag_reg        <= 1'b0;
      write_reg      <= 1'b0;
      feed_reg       <= 1'b0;
      rdr_reg        <= 1'b0;
      data_req_reg   <= 1'b0;
      ndr_reg        <= 1'b0;
      service_overlap_strobe_reg       <= 1'b0;
      svo_prev_reg   <= 1'b1;
      first_reg      <= 1'b1;
      accepted_reg   <= 7'h00;
      column_count   <= `CAC_PRESET_READ;
      nonzero_count  <= 8'h00;
      output_select  <= `CAC_SEL_CHAR;
      buffer_shift   <= 1'b0;
      buf_valid_reg  <= 1'b0;
      buf_data_reg   <= 12'h000;
      stacker_offset <= 1'b0;
    end else begin
      svo_prev_reg <= service_out;
      buffer_shift <= 1'b0;
      ndr_reg      <= 1'b0;
      if (buf_in_ready)
        buf_valid_reg <= 1'b0;
      if (load_phase_two)
        rdr_reg <= 1'b1;
      if (load_done)
        column_count <= `CAC_PRESET_READ;
      if (select_read && !card_image && !cmd_reg)
        output_select <= `CAC_SEL_CHAR;
      if (svo_fall && (select_read || select_punch))
        cmd_reg <= 1'b1;
      if (!select_punch)
        first_reg <= 1'b1;
      if (svo_fall && select_punch && first_reg) begin
        first_reg    <= 1'b0;
        write_reg    <= 1'b1;
        feed_reg     <= 1'b1;
        column_count <= `CAC_PRESET_WRITE;
        accepted_reg <= 7'h00;
      end
      if (xfer_done) begin
        cmd_reg        <= 1'b0;
        stacker_offset <= feed_command;
      end
      case (state_reg)
        ST_IDLE: begin
          if (svo_fall && select_read && !card_image && rdr_reg && !col_zero &&
              !terminate) begin
            state_reg <= ST_PULSE;
            timer_reg <= REQ_CYC;
          end else if (svo_fall && select_punch && !card_image &&
                       (write_reg || first_reg) && !terminate) begin
            xfer_reg  <= 1'b1;
            state_reg <= ST_TAG;
            timer_reg <= TAG_CYC;
          end
        end
        ST_PULSE: begin
          if (timer_reg == 8'h01) begin
            xfer_reg  <= cmd_reg;
            state_reg <= cmd_reg ? ST_TAG : ST_IDLE;
            timer_reg <= TAG_CYC;
          end else begin
            timer_reg <= timer_reg - 8'h01;
          end
        end
        ST_TAG: begin
          if (timer_reg == 8'h01) begin
            tag_reg   <= 1'b1;
            state_reg <= ST_WAIT;
          end else begin
            timer_reg <= timer_reg - 8'h01;
          end
        end
        ST_WAIT: begin
          if (svo_rise && select_read) begin
            data_req_reg <= 1'b1;
            ndr_reg      <= 1'b1;
            rdr_reg      <= 1'b0;
            buffer_shift <= 1'b1;
            xfer_reg     <= 1'b0;
            tag_reg      <= 1'b0;
            column_count <= col_zero ? column_count : column_count - 7'h01;
            rdr_reg      <= 1'b1;
            data_req_reg <= 1'b0;
            state_reg    <= ST_IDLE;
          end else if (svo_rise && select_punch && buf_in_ready) begin
            service_overlap_strobe_reg  <= 1'b1;
            timer_reg <= T4_CYC;
            buf_data_reg <= char_to_card(bus_out);
          end else if (service_overlap_strobe_reg) begin
            if (timer_reg == 8'h01) begin
              service_overlap_strobe_reg      <= 1'b0;
              xfer_reg      <= 1'b0;
              tag_reg       <= 1'b0;
              state_reg     <= ST_IDLE;
              column_count  <= column_count - 7'h01;
              buf_valid_reg <= 1'b1;
              if (bus_out != 8'h00)
                nonzero_count <= nonzero_count + 8'h01;
              accepted_reg  <= accepted_reg + 7'h01;
              if (accepted_reg == 7'h4F)
                write_reg <= 1'b0;
            end else begin
              timer_reg <= timer_reg - 8'h01;
            end
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end
endmodule // cac_channel_xfer
`default_nettype wire

// File: sim/cac_xfer_checker.sv
// Port assertions for the channel transfer block
`default_nettype none
module cac_xfer_checker (
  input wire logic       clk,
  input wire logic       srst,
  input wire logic       poll_active,
  input wire logic       status_accepted,
  input wire logic       status_stacked,
  input wire logic       select_read,
  input wire logic       select_punch,
  input wire logic       card_image,
  input wire logic       service_out,
  input wire logic       service_in,
  input wire logic       request_in,
  input wire logic [2:0] output_select,
  input wire logic       cmd_in_progress_flag,
  input wire logic       service_overlap_strobe,
  input wire logic       next_char_request,
  input wire logic [6:0] column_count,
  input wire logic [7:0] nonzero_count,
  input wire logic       service_exchange_active,
  input wire logic       xfer_done
);
  logic [15:0] low_reg;
  // Cycles with service out low
  always_ff @(posedge clk) begin
    if (srst || service_out) begin
      low_reg <= 16'h0000;
    end else if (low_reg != 16'hFFFF) begin
      low_reg <= low_reg + 16'h0001;
    end
  end
  default clocking dcb @(posedge clk);
  endclocking
  default disable iff (srst);
  acc_drop_a: assert property (poll_active && status_accepted |-> ##[1:4] !request_in)
    else $error("request held");
  req_hold_a: assert property (poll_active && status_stacked && request_in |=> request_in)
    else $error("request dropped");
  sel_code_a: assert property (select_read && !card_image && cmd_in_progress_flag
    |-> output_select == 3'h0) else $error("select code");
  rd_lat_a: assert property (select_read && $rose(service_in) |-> low_reg >= 16'h00BB)
    else $error("read answer early");
  pu_lat_a: assert property (select_punch && $rose(service_in) |-> low_reg >= 16'h0025)
    else $error("punch answer early");
  in_drop_a: assert property (select_read && service_in && $rose(service_out)
    |=> !service_in ##[0:1] next_char_request) else $error("input step");
  strobe_len_a: assert property ($rose(service_overlap_strobe)
    |-> service_overlap_strobe[*4] ##1 !service_overlap_strobe) else $error("strobe length");
  col_step_a: assert property (!$past(srst) && column_count != $past(column_count)
    |-> column_count == $past(column_count) - 7'h01 || column_count == 7'h63
    || column_count == 7'h4E) else $error("column step");
  nz_step_a: assert property (!$past(srst) && nonzero_count != $past(nonzero_count)
    |-> nonzero_count == $past(nonzero_count) + 8'h01) else $error("nonzero step");
  exch_act_a: assert property ($rose(service_overlap_strobe) |-> service_exchange_active)
    else $error("exchange inactive");
  done_clr_a: assert property (xfer_done |=> !cmd_in_progress_flag)
    else $error("command flag held");
  cover property ($rose(service_overlap_strobe));
  cover property (select_read && $fell(service_in));
  cover property (poll_active && status_stacked);
endmodule // cac_xfer_checker
bind cac_channel_xfer cac_xfer_checker u_chk (
  .clk, .srst, .poll_active, .status_accepted, .status_stacked, .select_read, .select_punch,
  .card_image, .service_out, .service_in, .request_in, .output_select, .cmd_in_progress_flag,
  .service_overlap_strobe, .next_char_request, .column_count, .nonzero_count,
  .service_exchange_active, .xfer_done
);
`default_nettype wire

// File: sim/cac_chan_model.sv
// Processor channel model driving the service out interlock
`default_nettype none
module cac_chan_model (
  input  wire logic       clk,
  input  wire logic       go,
  input  wire logic [7:0] slow,
  input  wire logic       service_in,
  output var  logic       service_out,
  output var  logic [7:0] bus_out,
  output var  logic [7:0] done_cnt,
  output var  logic [7:0] quiet_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  int         w;
  logic [7:0] data;
  initial begin
    {service_out, bus_out, done_cnt, quiet_cnt} = 25'h1FF0000;
    forever begin
      @(posedge clk);
      if (go === 1'b1) begin
        service_out <= 1'b0;
        for (w = 0; w < 400 && service_in !== 1'b1; w++)
          @(posedge clk);
        if (service_in === 1'b1) begin
          repeat (slow) @(posedge clk);
          data = (done_cnt[1:0] == 2'h0) ? 8'h00 : done_cnt;
          bus_out <= data;
          @(posedge clk);
          service_out <= 1'b1;
          for (w = 0; w < 400 && service_in !== 1'b0; w++)
            @(posedge clk);
          bus_out <= ~data;
          if (service_in === 1'b0)
            done_cnt <= done_cnt + 8'h01;
        end else begin
          service_out <= 1'b1;
          quiet_cnt <= quiet_cnt + 8'h01;
        end
      end
    end
  end
endmodule // cac_chan_model
`default_nettype wire

// File: sim/tb.sv
// Self-checking testbench for the channel transfer block
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk, srst, poll_active, status_accepted, status_stacked, status_pending_set;
  logic       select_read, select_punch, feed_command, load_phase_two, load_done, go;
  logic       buffer_ready, service_out, service_in, request_in, select_in_block;
  logic       write_in_progress_flag, stacker_offset, buffer_load_valid, buffer_shift;
  logic       terminate, feed_inhibit_flag, xfer_request_flag;
  logic [11:0] buffer_load_data;
  logic [7:0] bus_in;
  logic [2:0] output_select;
  logic [6:0] column_count;
  logic [7:0] nonzero_count, bus_out, slow, done_cnt, quiet_cnt, dev_addr, dev_stat;
  int         err_count, samples_checked, loads, shifts;
  cac_channel_xfer dut (
    .clk, .srst, .poll_active, .status_accepted, .status_stacked, .status_suppressed(1'b0),
    .status_pending_set, .device_address(dev_addr), .device_status(dev_stat), .select_read,
    .select_punch, .card_image(1'b0), .feed_command, .terminate, .load_phase_two,
    .load_done, .service_out, .bus_out, .buffer_head(12'hA5C), .buffer_ready, .request_in,
    .select_in_block, .bus_in, .service_in, .output_select, .cmd_in_progress_flag(),
    .xfer_request_flag, .write_in_progress_flag, .feed_inhibit_flag,
    .service_overlap_strobe(), .next_char_request(), .service_exchange_active(),
    .buffer_shift, .buffer_load_valid, .buffer_load_data, .column_count, .nonzero_count,
    .stacker_offset, .xfer_done()
  );
  cac_chan_model m_chan (
    .clk, .go, .slow, .service_in, .service_out, .bus_out, .done_cnt, .quiet_cnt
  );
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    shifts += (buffer_shift === 1'b1);
    loads += (select_punch && buffer_load_valid === 1'b1 && buffer_ready === 1'b1);
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic poll(input logic stack, input logic [7:0] st);
    dev_stat = st;
    poll_active = 1'b1;
    @(negedge clk);
    chk("bus_in address", {8'h00, dev_addr}, bus_in);
    @(negedge clk);
    chk("bus_in status", {8'h00, st}, bus_in);
    status_stacked = stack;
    status_accepted = !stack;
    repeat (2) @(negedge clk);
    {poll_active, status_stacked, status_accepted} = 3'h0;
    repeat (3) @(negedge clk);
  endtask
  task automatic xfer(input logic [7:0] q);
    go = 1'b1;
    for (int i = 0; i < 40000 && quiet_cnt !== q; i++)
      @(negedge clk);
    go = 1'b0;
    @(negedge clk);
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    {poll_active, status_accepted, status_stacked, status_pending_set} = 4'h0;
    {select_read, select_punch, feed_command, load_phase_two, load_done, go, terminate} = 7'h00;
    {srst, buffer_ready, slow, dev_addr, dev_stat} = {2'h3, 8'h00, 8'h3C, 8'h0C};
    repeat (8) @(negedge clk);
    srst = 1'b0;
    @(negedge clk);
    chk("column_count", 16'h004E, column_count);
    status_pending_set = 1'b1;
    @(negedge clk);
    status_pending_set = 1'b0;
    repeat (2) @(negedge clk);
    chk("request_in", 16'h0001, request_in);
    poll(1'b1, 8'h0C);
    chk("request_in", 16'h0001, request_in);
    chk("select_in_block", 16'h0001, select_in_block);
    poll(1'b0, 8'h04);
    chk("request_in", 16'h0000, request_in);
    chk("select_in_block", 16'h0000, select_in_block);
    $display("test poll done");
    select_read = 1'b1;
    load_phase_two = 1'b1;
    @(negedge clk);
    load_phase_two = 1'b0;
    load_done = 1'b1;
    @(negedge clk);
    load_done = 1'b0;
    repeat (2) @(negedge clk);
    chk("output_select", 16'h0000, output_select);
    slow = 8'h14;
    xfer(8'h01);
    chk("read bytes", 16'h004E, done_cnt);
    chk("column_count", 16'h0000, column_count);
    chk("shifts", 16'h004E, shifts[15:0]);
    chk("bus_in", 16'h00AC, bus_in);
    $display("test read done");
    {select_read, select_punch, feed_command, buffer_ready, slow} = {4'h6, 8'h00};
    go = 1'b1;
    for (int i = 0; i < 9000 && done_cnt !== 8'h50; i++)
      @(negedge clk);
    chk("buffer_load_valid", 16'h0001, buffer_load_valid);
    chk("write_in_progress_flag", 16'h0001, write_in_progress_flag);
    chk("buffer_load_data", 16'h040E, buffer_load_data);
    buffer_ready = 1'b1;
    xfer(8'h02);
    chk("punch bytes", 16'h009E, done_cnt);
    chk("column_count", 16'h0013, column_count);
    chk("nonzero_count", 16'h003C, nonzero_count);
    chk("write_in_progress_flag", 16'h0000, write_in_progress_flag);
    chk("loads", 16'h0050, loads[15:0]);
    chk("stacker_offset", 16'h0001, stacker_offset);
    chk("feed_inhibit_flag", 16'h0001, feed_inhibit_flag);
    chk("xfer_request_flag", 16'h0000, xfer_request_flag);
    $display("test punch done");
    {select_punch, select_read, terminate} = 3'h3;
    load_done = 1'b1;
    @(negedge clk);
    load_done = 1'b0;
    xfer(8'h03);
    chk("column_count", 16'h004E, column_count);
    chk("term bytes", 16'h009E, done_cnt);
    $display("test terminate done");
    end_of_test();
  end
  initial begin
    repeat (60000) @(posedge clk);
    $display("watchdog expired");
    err_count++;
    end_of_test();
  end
endmodule // tb
`default_nettype wire
